// File: include/cdsf_pkg.sv
// Constants for the console device status flag block
package cdsf_pkg;
  // ==========================================================
  // Read port
  localparam logic [4:0] DEV_ADDR = 5'h00;
  localparam int NUM_BYTES = 3;
  localparam logic [1:0] IDX_GENERAL = 2'h0;
  localparam logic [1:0] IDX_WINDOW = 2'h1;
  localparam logic [1:0] IDX_POWER = 2'h2;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // ==========================================================
  // Bit positions, accumulator bit Bn sits at index n-1
  localparam int G_INTERLOCK = 0;
  localparam int G_POSITIONED = 1;
  localparam int G_INVALID_KEY = 2;
  localparam int G_IDLE = 3;
  localparam int G_PAPER = 6;
  localparam int G_VELOCITY = 7;
  localparam int W_PB_FIRST = 0;
  localparam int W_PB_FOLD = 1;
  localparam int W_PB_LAST = 2;
  localparam int W_LOCK_A = 5;
  localparam int W_LOCK_B = 6;
  localparam int W_LOCK_SV = 7;
  localparam int P_BATT_ON = 0;
  localparam int P_NO_BOARD = 1;
  localparam int P_PARITY = 2;
  localparam int P_BATT_EN = 4;
  localparam int P_LOW_LINE = 7;
  // ==========================================================
  // Port control command codes
  localparam logic [7:0] CMD_SET_OUT_INHIBIT = 8'h1D;
  localparam logic [7:0] CMD_CLR_OUT_INHIBIT = 8'h15;
  localparam logic [7:0] CMD_KEYBOARD_ENABLE = 8'h03;
  localparam logic [7:0] CMD_SET_INVALID_KEY = 8'h43;
  localparam logic [7:0] CMD_CLR_INVALID_KEY = 8'h63;
  localparam logic [7:0] CMD_SET_BATT_ENABLE = 8'h83;
  localparam logic [7:0] CMD_KEYBOARD_INHIBIT = 8'hA3;
  // ==========================================================
  // Synchronised pin indexes
  localparam int SYNC_W = 16;
  localparam int S_LEDGER = 0;
  localparam int S_KEY = 1;
  localparam int S_PAPER_OUT = 2;
  localparam int S_OVERSPEED = 3;
  localparam int S_HOLD_REL = 4;
  localparam int S_UNDERSPEED = 5;
  localparam int S_ENGAGE_FAIL = 6;
  localparam int S_PRINT_START = 7;
  localparam int S_PB_FIRST = 8;
  localparam int S_PB_FOLD = 9;
  localparam int S_PB_LAST = 10;
  localparam int S_LOCK_A = 11;
  localparam int S_LOCK_B = 12;
  localparam int S_LOCK_SV = 13;
  localparam int S_UNDERVOLT = 14;
  localparam int S_LOW_LINE = 15;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 16'h0000;
endpackage

// File: include/cdsf_sync_if.sv
// Carrier between the pin synchroniser and the status logic
`timescale 1ns/1ps
interface cdsf_sync_if;
  logic [cdsf_pkg::SYNC_W-1:0] raw;
  logic [cdsf_pkg::SYNC_W-1:0] clean;
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface

// File: core/cdsf_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cdsf_sync (
  input wire logic sys_clk,
  input wire logic rst,
  cdsf_sync_if.sync_side pins
);
  logic [cdsf_pkg::SYNC_W-1:0] s1_r;
  logic [cdsf_pkg::SYNC_W-1:0] s2_r;
  logic [cdsf_pkg::SYNC_W-1:0] s3_r;
  logic [cdsf_pkg::SYNC_W-1:0] clean_r;

  // ==========================================================
  // Per-pin chain; first stage feeds only the second
  genvar i;
  for (i = 0; i < cdsf_pkg::SYNC_W; i++) begin : g_pin
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        clean_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= pins.raw[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        // Only a level that held for two samples counts
        if (s2_r[i] == s3_r[i]) begin
          clean_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign pins.clean = clean_r;
endmodule

// File: core/cdsf_status.sv
// Console device status bytes, flags and print idle line
`timescale 1ns/1ps

// How it works
// [RULE1] Byte two: override, teller B, teller A locks
// [RULE2] Byte three: battery on, no board, parity
// [RULE3] Byte three: bit4 zero, battery enabled, low line
// [RULE4] Host avoids ledger ops while interlock set
// [RULE5] Positioned bit follows gripper ledger transducer
// [RULE6] Key while inhibited sets invalid key flag
// [RULE7] Command sets or clears; port init clears
// [RULE8] Idle only when mechanism idle, buffer empty
// [RULE9] Output inhibit shows buffer empty to micro
// [RULE10] Idle also driven on ledger reader line
// [RULE11] Any buffered code holds idle low until done
// [RULE12] Out of paper follows paper detector directly
// [RULE13] No command touches the out of paper bit
// [RULE14] Overspeed at hold release sets velocity error
// [RULE15] Underspeed or engage failure sets velocity error
// [RULE16] Port init clears velocity error
// [RULE17] Velocity error forces idle low, blocks operations
// [RULE18] Reads step byte one, two, three
// [RULE19] Window option absent: byte two zero
// [RULE20] Status bits read one when condition present
// [RULE21] Host reads status at address zero
// [RULE22] Unused bits of all bytes read zero
module cdsf_status (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic [4:0] rd_addr,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic port_init,
  input wire logic ledger_present_pin,
  input wire logic key_press_pin,
  input wire logic paper_absent_pin,
  input wire logic overspeed_pin,
  input wire logic hold_release_pin,
  input wire logic underspeed_pin,
  input wire logic engage_fail_pin,
  input wire logic print_start_pin,
  input wire logic pb_first_pin,
  input wire logic pb_fold_pin,
  input wire logic pb_last_pin,
  input wire logic lock_a_pin,
  input wire logic lock_b_pin,
  input wire logic lock_sv_pin,
  input wire logic undervoltage_pin,
  input wire logic low_line_pin,
  input wire logic window_option,
  input wire logic interlock_required,
  input wire logic mech_idle,
  input wire logic out_fifo_empty,
  input wire logic micro_busy,
  input wire logic auto_reader_active,
  input wire logic mem_absent_hit,
  input wire logic mem_parity_hit,
  output logic buf_empty_to_micro,
  output logic print_mechanism_idle,
  output logic pcf_op_enable,
  output logic alarm_enable
);
  cdsf_sync_if sif ();

  // ==========================================================
  // Pin capture
  assign sif.raw[cdsf_pkg::S_LEDGER] = ledger_present_pin;
  assign sif.raw[cdsf_pkg::S_KEY] = key_press_pin;
  assign sif.raw[cdsf_pkg::S_PAPER_OUT] = paper_absent_pin;
  assign sif.raw[cdsf_pkg::S_OVERSPEED] = overspeed_pin;
  assign sif.raw[cdsf_pkg::S_HOLD_REL] = hold_release_pin;
  assign sif.raw[cdsf_pkg::S_UNDERSPEED] = underspeed_pin;
  assign sif.raw[cdsf_pkg::S_ENGAGE_FAIL] = engage_fail_pin;
  assign sif.raw[cdsf_pkg::S_PRINT_START] = print_start_pin;
  assign sif.raw[cdsf_pkg::S_PB_FIRST] = pb_first_pin;
  assign sif.raw[cdsf_pkg::S_PB_FOLD] = pb_fold_pin;
  assign sif.raw[cdsf_pkg::S_PB_LAST] = pb_last_pin;
  assign sif.raw[cdsf_pkg::S_LOCK_A] = lock_a_pin;
  assign sif.raw[cdsf_pkg::S_LOCK_B] = lock_b_pin;
  assign sif.raw[cdsf_pkg::S_LOCK_SV] = lock_sv_pin;
  assign sif.raw[cdsf_pkg::S_UNDERVOLT] = undervoltage_pin;
  assign sif.raw[cdsf_pkg::S_LOW_LINE] = low_line_pin;

  cdsf_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pins(sif.sync_side)
  );

  logic [cdsf_pkg::SYNC_W-1:0] pin;
  logic [cdsf_pkg::SYNC_W-1:0] pin_d_r;
  logic [cdsf_pkg::SYNC_W-1:0] rise;
  assign pin = sif.clean;
  assign rise = pin & ~pin_d_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_d_r <= cdsf_pkg::SYNC_RESET;
    end else begin
      pin_d_r <= pin;
    end
  end

  // ==========================================================
  // Command decode
  logic do_cmd;
  logic cmd_set_inh;
  logic cmd_clr_inh;
  logic cmd_kb_en;
  logic cmd_kb_inh;
  logic cmd_set_inv_key;
  logic cmd_clr_inv_key;
  logic cmd_set_ben;
  assign do_cmd = cmd_valid;
  assign cmd_set_inh = do_cmd && cmd_code == cdsf_pkg::CMD_SET_OUT_INHIBIT;
  assign cmd_clr_inh = do_cmd && cmd_code == cdsf_pkg::CMD_CLR_OUT_INHIBIT;
  assign cmd_kb_en = do_cmd && cmd_code == cdsf_pkg::CMD_KEYBOARD_ENABLE;
  assign cmd_kb_inh = do_cmd && cmd_code == cdsf_pkg::CMD_KEYBOARD_INHIBIT;
  assign cmd_set_inv_key = do_cmd && cmd_code == cdsf_pkg::CMD_SET_INVALID_KEY;
  assign cmd_clr_inv_key = do_cmd && cmd_code == cdsf_pkg::CMD_CLR_INVALID_KEY;
  assign cmd_set_ben = do_cmd && cmd_code == cdsf_pkg::CMD_SET_BATT_ENABLE;

  // ==========================================================
  // Keyboard inhibit and invalid key flag
  logic kb_inhibit_r;
  logic invalid_key_entry_r;
  logic key_event;

  always_ff @(posedge sys_clk) begin
    if (rst || port_init || cmd_kb_en) begin
      kb_inhibit_r <= 1'b0;
    end else if (cmd_kb_inh) begin
      kb_inhibit_r <= 1'b1;
    end
  end

  assign key_event = rise[cdsf_pkg::S_KEY] && kb_inhibit_r; // RULE6

  // Set beats clear so a key in the clearing cycle is not lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      invalid_key_entry_r <= 1'b0;
    end else if (key_event || cmd_set_inv_key) begin
      invalid_key_entry_r <= 1'b1; // RULE6 RULE7
    end else if (cmd_clr_inv_key || port_init) begin
      invalid_key_entry_r <= 1'b0; // RULE7
    end
  end

  // ==========================================================
  // Carrier velocity error
  logic carrier_velocity_error_r;
  logic overspeed_event;
  logic velocity_event;
  assign overspeed_event = rise[cdsf_pkg::S_HOLD_REL] && pin[cdsf_pkg::S_OVERSPEED]; // RULE14
  assign velocity_event = overspeed_event
                       || rise[cdsf_pkg::S_UNDERSPEED]
                       || (rise[cdsf_pkg::S_PRINT_START] && pin[cdsf_pkg::S_ENGAGE_FAIL]); // RULE15

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      carrier_velocity_error_r <= 1'b0;
    end else if (velocity_event) begin
      carrier_velocity_error_r <= 1'b1; // RULE14 RULE15
    end else if (port_init) begin
      carrier_velocity_error_r <= 1'b0; // RULE16
    end
  end

  // ==========================================================
  // Output buffer inhibit and idle
  logic out_inhibit_r;
  logic idle_r;
  logic idle_nxt;

  always_ff @(posedge sys_clk) begin
    if (rst || port_init || cmd_clr_inh) begin
      out_inhibit_r <= 1'b0;
    end else if (cmd_set_inh) begin
      out_inhibit_r <= 1'b1;
    end
  end

  // Auto reader output must not reach the print micro while inhibited
  assign buf_empty_to_micro = out_fifo_empty || (out_inhibit_r && auto_reader_active); // RULE9

  // Idle waits for the micro to finish, so even no-op codes hold it low
  assign idle_nxt = mech_idle && buf_empty_to_micro && !micro_busy // RULE8 RULE11
                 && !carrier_velocity_error_r; // RULE17

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      idle_r <= 1'b0;
    end else begin
      idle_r <= idle_nxt;
    end
  end

  assign print_mechanism_idle = idle_r; // RULE10
  assign pcf_op_enable = !carrier_velocity_error_r; // RULE17
  assign alarm_enable = 1'b1; // RULE17

  // ==========================================================
  // Processor power and memory flags
  logic battery_on_r;
  logic no_board_r;
  logic parity_r;
  logic batt_enabled_r;
  logic read_power;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      battery_on_r <= 1'b0;
    end else if (rise[cdsf_pkg::S_UNDERVOLT]) begin
      battery_on_r <= 1'b1; // RULE2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      batt_enabled_r <= 1'b0;
    end else if (cmd_set_ben) begin
      batt_enabled_r <= 1'b1; // RULE3
    end
  end

  // Reading byte three clears these; a hit in that cycle survives
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      no_board_r <= 1'b0;
    end else if (mem_absent_hit) begin
      no_board_r <= 1'b1; // RULE2
    end else if (read_power) begin
      no_board_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      parity_r <= 1'b0;
    end else if (mem_parity_hit) begin
      parity_r <= 1'b1; // RULE2
    end else if (read_power) begin
      parity_r <= 1'b0;
    end
  end

  // ==========================================================
  // Byte assembly
  logic [7:0] general_byte;
  logic [7:0] window_byte;
  logic [7:0] power_byte;

  always_comb begin
    general_byte = cdsf_pkg::BYTE_RESET; // RULE22
    general_byte[cdsf_pkg::G_INTERLOCK] = interlock_required; // RULE20
    general_byte[cdsf_pkg::G_POSITIONED] = pin[cdsf_pkg::S_LEDGER]; // RULE5
    general_byte[cdsf_pkg::G_INVALID_KEY] = invalid_key_entry_r;
    general_byte[cdsf_pkg::G_IDLE] = idle_r; // RULE8
    general_byte[cdsf_pkg::G_PAPER] = pin[cdsf_pkg::S_PAPER_OUT]; // RULE12 RULE13
    general_byte[cdsf_pkg::G_VELOCITY] = carrier_velocity_error_r;
  end

  always_comb begin
    window_byte = cdsf_pkg::BYTE_RESET; // RULE22
    if (window_option) begin // RULE19
      window_byte[cdsf_pkg::W_PB_FIRST] = pin[cdsf_pkg::S_PB_FIRST];
      window_byte[cdsf_pkg::W_PB_FOLD] = pin[cdsf_pkg::S_PB_FOLD];
      window_byte[cdsf_pkg::W_PB_LAST] = pin[cdsf_pkg::S_PB_LAST];
      window_byte[cdsf_pkg::W_LOCK_A] = pin[cdsf_pkg::S_LOCK_A]; // RULE1
      window_byte[cdsf_pkg::W_LOCK_B] = pin[cdsf_pkg::S_LOCK_B]; // RULE1
      window_byte[cdsf_pkg::W_LOCK_SV] = pin[cdsf_pkg::S_LOCK_SV]; // RULE1
    end
  end

  always_comb begin
    power_byte = cdsf_pkg::BYTE_RESET; // RULE3 RULE22
    power_byte[cdsf_pkg::P_BATT_ON] = battery_on_r; // RULE2
    power_byte[cdsf_pkg::P_NO_BOARD] = no_board_r; // RULE2
    power_byte[cdsf_pkg::P_PARITY] = parity_r; // RULE2
    power_byte[cdsf_pkg::P_BATT_EN] = batt_enabled_r; // RULE3
    power_byte[cdsf_pkg::P_LOW_LINE] = pin[cdsf_pkg::S_LOW_LINE]; // RULE3
  end

  // ==========================================================
  // Read sequencing
  logic [1:0] byte_idx_r;
  logic dev_read;
  assign dev_read = rd_req && rd_addr == cdsf_pkg::DEV_ADDR; // RULE21
  assign read_power = dev_read && byte_idx_r == cdsf_pkg::IDX_POWER;

  // Port init restarts the sequence at byte one
  always_ff @(posedge sys_clk) begin
    if (rst || port_init) begin
      byte_idx_r <= cdsf_pkg::IDX_GENERAL;
    end else if (dev_read) begin
      byte_idx_r <= (byte_idx_r == cdsf_pkg::IDX_POWER) ? cdsf_pkg::IDX_GENERAL
                                                       : byte_idx_r + 2'h1; // RULE18
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= cdsf_pkg::BYTE_RESET;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= dev_read;
      if (dev_read) begin
        unique case (byte_idx_r)
          cdsf_pkg::IDX_GENERAL: rd_data <= general_byte;
          cdsf_pkg::IDX_WINDOW: rd_data <= window_byte;
          cdsf_pkg::IDX_POWER: rd_data <= power_byte;
          default: rd_data <= cdsf_pkg::BYTE_RESET;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_read_order_step: assert property ( // RULE18
    dev_read && !port_init |=> byte_idx_r == (($past(byte_idx_r) == 2'h2) ? 2'h0 : $past(byte_idx_r) + 2'h1))
    else $error("byte sequence did not step");
  a_window_absent_zero: assert property ( // RULE19
    dev_read && byte_idx_r == 2'h1 && !window_option |=> rd_data == 8'h00)
    else $error("window byte not zero");
  a_power_unused_zero: assert property ( // RULE3
    dev_read && byte_idx_r == 2'h2 |=> rd_data[3] == 1'b0 && rd_data[6:5] == 2'h0)
    else $error("power byte unused bits set");
  a_general_unused_zero: assert property ( // RULE22
    dev_read && byte_idx_r == 2'h0 |=> rd_data[5:4] == 2'h0 && rd_data[7] == $past(carrier_velocity_error_r))
    else $error("general byte layout wrong");
  a_key_sets_flag: assert property ( // RULE6
    key_event |=> invalid_key_entry_r)
    else $error("invalid key flag not set");
  a_init_clears_key: assert property ( // RULE7
    port_init && !key_event && !cmd_set_inv_key |=> !invalid_key_entry_r)
    else $error("invalid key flag survived init");
  a_velocity_holds_idle: assert property ( // RULE17
    carrier_velocity_error_r |-> !pcf_op_enable ##1 !idle_r)
    else $error("idle high with velocity error");
  a_overspeed_sets: assert property ( // RULE14
    overspeed_event ##1 !port_init |-> carrier_velocity_error_r [*2])
    else $error("overspeed did not latch error");
  a_init_clears_velocity: assert property ( // RULE16
    port_init && !velocity_event |=> !carrier_velocity_error_r)
    else $error("velocity error survived init");
  a_busy_holds_idle: assert property ( // RULE11
    micro_busy |=> !print_mechanism_idle)
    else $error("idle high while micro busy");
  a_inhibit_shows_empty: assert property ( // RULE9
    out_inhibit_r && auto_reader_active |-> buf_empty_to_micro)
    else $error("inhibited buffer not shown empty");
  a_parity_read_clear: assert property ( // RULE2
    read_power && !mem_parity_hit |=> !parity_r && rd_data[2] == $past(parity_r))
    else $error("parity flag read or clear wrong");
endmodule

// File: testbench/cdsf_host.sv
// Host processor model that reads status bytes and issues port commands
`timescale 1ns/1ps
module cdsf_host (
  input wire logic sys_clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_req,
  output logic [4:0] rd_addr,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic port_init
);
  // ==========================================================
  // Idle levels
  // The idle address is the inverse of the device address, so a read cannot
  // match it by accident when no read is in progress
  initial begin
    rd_req = 1'b0;
    rd_addr = ~cdsf_pkg::DEV_ADDR;
    cmd_valid = 1'b0;
    cmd_code = 8'hFF;
    port_init = 1'b0;
  end
  // ==========================================================
  // Bus cycles
  // Reads, commands and port init only, so ledger work is never started
  // while the interlock bit is set
  task automatic rd(input logic [4:0] a, output logic v, output logic [7:0] d);
    @(negedge sys_clk);
    rd_req = 1'b1;
    rd_addr = a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    v = rd_valid;
    d = rd_data;
    rd_req = 1'b0;
    rd_addr = ~a;
  endtask
  task automatic cmd(input logic [7:0] c);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code = ~c;
  endtask
  task automatic init();
    @(negedge sys_clk);
    port_init = 1'b1;
    @(negedge sys_clk);
    port_init = 1'b0;
  endtask
endmodule

// File: testbench/console_device_status_flags_tb.sv
// Self-checking testbench for the console status flag block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module console_device_status_flags_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic rd_req, rd_valid, cmd_valid, port_init;
  logic [4:0] rd_addr;
  logic [7:0] rd_data, cmd_code;
  logic ledger = 0, key = 0, paper = 0, ovs = 0, hold = 0, uns = 0, engf = 0, pstart = 0;
  logic [5:0] win = 6'h00;
  logic undv = 0, lowl = 0, wopt = 0, ilock = 0, midle = 0, fempty = 1, busy = 0;
  logic autor = 0, mabs = 0, mpar = 0;
  logic buf_empty, idle_line, pcf_en, alarm_en;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic v;
  logic [7:0] d;
  // ==========================================================
  // Clock, timeout and instances
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  cdsf_host u_host (.sys_clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data), .rd_req(rd_req),
    .rd_addr(rd_addr), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .port_init(port_init));
  cdsf_status u_dut (.sys_clk(sys_clk), .rst(rst), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .port_init(port_init), .ledger_present_pin(ledger), .key_press_pin(key),
    .paper_absent_pin(paper), .overspeed_pin(ovs), .hold_release_pin(hold),
    .underspeed_pin(uns), .engage_fail_pin(engf), .print_start_pin(pstart),
    .pb_first_pin(win[0]), .pb_fold_pin(win[1]), .pb_last_pin(win[2]), .lock_a_pin(win[3]),
    .lock_b_pin(win[4]), .lock_sv_pin(win[5]), .undervoltage_pin(undv), .low_line_pin(lowl),
    .window_option(wopt), .interlock_required(ilock), .mech_idle(midle),
    .out_fifo_empty(fempty), .micro_busy(busy), .auto_reader_active(autor),
    .mem_absent_hit(mabs), .mem_parity_hit(mpar), .buf_empty_to_micro(buf_empty),
    .print_mechanism_idle(idle_line), .pcf_op_enable(pcf_en), .alarm_enable(alarm_en));
  // ==========================================================
  // Shared tasks
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic read_set(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
    u_host.rd(cdsf_pkg::DEV_ADDR, v, d);
    `CHK("valid", 1'b1, v)
    `CHK("byte1", e1, d)
    u_host.rd(cdsf_pkg::DEV_ADDR, v, d);
    `CHK("byte2", e2, d)
    u_host.rd(cdsf_pkg::DEV_ADDR, v, d);
    `CHK("byte3", e3, d)
  endtask
  task automatic end_test(input string nm);
    $display("test %s done, errors so far %0d", nm, num_errors);
  endtask
  // Synchronised pins need a few cycles before they show
  task automatic pulse_pin(ref logic p);
    p = 1'b1;
    wt(8);
    p = 1'b0;
    wt(8);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    wt(5);
    rst = 1'b0;
    u_host.rd(5'h01, v, d);
    `CHK("foreign addr valid", 1'b0, v)
    read_set(8'h00, 8'h00, 8'h00);
    `CHK("alarm", 1'b1, alarm_en)
    end_test("reset");
    ilock = 1'b1;
    ledger = 1'b1;
    paper = 1'b1;
    wt(8);
    read_set(8'h43, 8'h00, 8'h00);
    u_host.cmd(cdsf_pkg::CMD_SET_OUT_INHIBIT);
    u_host.cmd(cdsf_pkg::CMD_CLR_OUT_INHIBIT);
    u_host.cmd(cdsf_pkg::CMD_KEYBOARD_ENABLE);
    u_host.cmd(cdsf_pkg::CMD_CLR_INVALID_KEY);
    read_set(8'h43, 8'h00, 8'h00);
    ilock = 1'b0;
    ledger = 1'b0;
    paper = 1'b0;
    wt(8);
    read_set(8'h00, 8'h00, 8'h00);
    end_test("general");
    u_host.cmd(cdsf_pkg::CMD_SET_INVALID_KEY);
    read_set(8'h04, 8'h00, 8'h00);
    u_host.cmd(cdsf_pkg::CMD_CLR_INVALID_KEY);
    pulse_pin(key);
    read_set(8'h00, 8'h00, 8'h00);
    u_host.cmd(cdsf_pkg::CMD_KEYBOARD_INHIBIT);
    pulse_pin(key);
    read_set(8'h04, 8'h00, 8'h00);
    u_host.init();
    read_set(8'h00, 8'h00, 8'h00);
    end_test("invalid key");
    midle = 1'b1;
    wt(3);
    `CHK("idle line", 1'b1, idle_line)
    read_set(8'h08, 8'h00, 8'h00);
    fempty = 1'b0;
    wt(3);
    `CHK("idle busy fifo", 1'b0, idle_line)
    `CHK("empty to micro", 1'b0, buf_empty)
    autor = 1'b1;
    u_host.cmd(cdsf_pkg::CMD_SET_OUT_INHIBIT);
    wt(2);
    `CHK("inhibit empty", 1'b1, buf_empty)
    `CHK("inhibit idle", 1'b1, idle_line)
    busy = 1'b1;
    wt(3);
    `CHK("micro busy idle", 1'b0, idle_line)
    busy = 1'b0;
    u_host.cmd(cdsf_pkg::CMD_CLR_OUT_INHIBIT);
    wt(2);
    `CHK("inhibit off", 1'b0, buf_empty)
    fempty = 1'b1;
    autor = 1'b0;
    wt(3);
    end_test("idle");
    ovs = 1'b1;
    pulse_pin(hold);
    ovs = 1'b0;
    read_set(8'h80, 8'h00, 8'h00);
    `CHK("idle vel", 1'b0, idle_line)
    `CHK("pcf enable", 1'b0, pcf_en)
    `CHK("alarm vel", 1'b1, alarm_en)
    u_host.init();
    wt(3);
    read_set(8'h08, 8'h00, 8'h00);
    `CHK("pcf back", 1'b1, pcf_en)
    pulse_pin(uns);
    read_set(8'h80, 8'h00, 8'h00);
    u_host.init();
    engf = 1'b1;
    pulse_pin(pstart);
    engf = 1'b0;
    read_set(8'h80, 8'h00, 8'h00);
    u_host.init();
    midle = 1'b0;
    wt(3);
    read_set(8'h00, 8'h00, 8'h00);
    end_test("velocity");
    wopt = 1'b1;
    win = 6'h31;
    wt(8);
    read_set(8'h00, 8'hC1, 8'h00);
    win = 6'h0E;
    wt(8);
    read_set(8'h00, 8'h26, 8'h00);
    wopt = 1'b0;
    wt(2);
    read_set(8'h00, 8'h00, 8'h00);
    win = 6'h00;
    end_test("window");
    pulse_pin(undv);
    u_host.cmd(cdsf_pkg::CMD_SET_BATT_ENABLE);
    @(negedge sys_clk);
    mabs = 1'b1;
    @(negedge sys_clk);
    mabs = 1'b0;
    mpar = 1'b1;
    @(negedge sys_clk);
    mpar = 1'b0;
    lowl = 1'b1;
    wt(8);
    read_set(8'h00, 8'h00, 8'h97);
    read_set(8'h00, 8'h00, 8'h91);
    lowl = 1'b0;
    wt(8);
    read_set(8'h00, 8'h00, 8'h11);
    end_test("power");
    give_verdict();
  end
endmodule
